// [rtl/dms_config_bank.sv]
// drive mode and stop configuration bank with brake release command gate
`timescale 1ns/1ns
`include "dms_map.svh"
`default_nettype none
module dms_config_bank #(
   parameter int MS_CYCLES = `DMS_MS_NS / `DMS_CLK_NS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic wrReq,
   input wire logic rdReq,
   input wire logic [15:0] addr,
   input wire logic [15:0] wrData,
   output logic [15:0] rdData,
   output logic ack,
   output logic reject,
   input wire logic driveStopped,
   input wire logic brakeReleaseOn,
   output logic cmdAccept,
   output logic speedModeEn,
   output logic positionModeEn,
   output logic torqueModeEn,
   output logic segmentModeEn,
   output dms_pkg::dms_abs_t absMode,
   output logic clockwiseForward,
   output logic phaseALags,
   output dms_pkg::dms_act_t enOffAct,
   output dms_pkg::dms_end_t enOffEnd,
   output dms_pkg::dms_act_t c2Act,
   output dms_pkg::dms_end_t c2End,
   output dms_pkg::dms_act_t otAct,
   output dms_pkg::dms_end_t otEnd,
   output logic otIgnore,
   output dms_pkg::dms_act_t c1Act,
   output dms_pkg::dms_end_t c1End
);
   import dms_pkg::*;

   // ************************************************
   // reset release
   // ************************************************
   logic rstMeta;
   logic rstSyncN;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   // ************************************************
   // stop selection decode
   // ************************************************
   function automatic logic [4:0] decEnOff(input logic [15:0] v);
      case (v)
         16'h0000: decEnOff = {DMS_ACT_COAST, DMS_END_OFF};
         16'h0001: decEnOff = {DMS_ACT_RAMP1, DMS_END_OFF};
         16'h0002: decEnOff = {DMS_ACT_DBRAKE, DMS_END_OFF};
         16'hffff: decEnOff = {DMS_ACT_DBRAKE, DMS_END_DB};
         16'hfffe: decEnOff = {DMS_ACT_RAMP1, DMS_END_DB};
         16'hfffd: decEnOff = {DMS_ACT_ZERO, DMS_END_DB};
         16'hfffc: decEnOff = {DMS_ACT_RAMP2, DMS_END_DB};
         default: decEnOff = {DMS_ACT_COAST, DMS_END_OFF};
      endcase
   endfunction : decEnOff

   function automatic logic [4:0] decC2(input logic [15:0] v);
      case (v)
         16'h0000: decC2 = {DMS_ACT_COAST, DMS_END_OFF};
         16'h0001: decC2 = {DMS_ACT_RAMP1, DMS_END_OFF};
         16'h0002: decC2 = {DMS_ACT_RAMP2, DMS_END_OFF};
         16'h0003: decC2 = {DMS_ACT_ETORQ, DMS_END_OFF};
         16'h0004: decC2 = {DMS_ACT_DBRAKE, DMS_END_OFF};
         16'hffff: decC2 = {DMS_ACT_DBRAKE, DMS_END_DB};
         16'hfffe: decC2 = {DMS_ACT_RAMP1, DMS_END_DB};
         16'hfffd: decC2 = {DMS_ACT_RAMP2, DMS_END_DB};
         16'hfffc: decC2 = {DMS_ACT_ETORQ, DMS_END_DB};
         16'hfffb: decC2 = {DMS_ACT_ZERO, DMS_END_DB};
         default: decC2 = {DMS_ACT_RAMP2, DMS_END_OFF};
      endcase
   endfunction : decC2

   function automatic logic [4:0] decOt(input logic [15:0] v);
      case (v)
         16'h0000: decOt = {DMS_ACT_COAST, DMS_END_OFF};
         16'h0001: decOt = {DMS_ACT_ZERO, DMS_END_LOCK};
         16'h0002: decOt = {DMS_ACT_ZERO, DMS_END_OFF};
         16'h0003: decOt = {DMS_ACT_RAMP2, DMS_END_OFF};
         16'h0004: decOt = {DMS_ACT_RAMP2, DMS_END_LOCK};
         16'h0005: decOt = {DMS_ACT_DBRAKE, DMS_END_OFF};
         16'h0006: decOt = {DMS_ACT_DBRAKE, DMS_END_DB};
         16'h0007: decOt = {DMS_ACT_NONE, DMS_END_RUN};
         default: decOt = {DMS_ACT_ZERO, DMS_END_LOCK};
      endcase
   endfunction : decOt

   function automatic logic [4:0] decC1(input logic [15:0] v);
      case (v)
         16'h0000: decC1 = {DMS_ACT_COAST, DMS_END_OFF};
         16'h0001: decC1 = {DMS_ACT_DBRAKE, DMS_END_OFF};
         default: decC1 = {DMS_ACT_DBRAKE, DMS_END_DB};
      endcase
   endfunction : decC1

   // ************************************************
   // access decode and value checks
   // ************************************************
   logic [15:0] modeReg, absReg, dirReg, phaseReg, enOffReg;
   logic [15:0] c2Reg, otReg, c1Reg, delayReg;
   wire selMode = addr == `DMS_ADDR_MODE;
   wire selAbs = addr == `DMS_ADDR_ABS;
   wire selDir = addr == `DMS_ADDR_DIR;
   wire selPhase = addr == `DMS_ADDR_PHASE;
   wire selEnOff = addr == `DMS_ADDR_ENOFF;
   wire selC2 = addr == `DMS_ADDR_C2;
   wire selOt = addr == `DMS_ADDR_OT;
   wire selC1 = addr == `DMS_ADDR_C1;
   wire selDelay = addr == `DMS_ADDR_DELAY;
   wire mapped = selMode | selAbs | selDir | selPhase | selEnOff
      | selC2 | selOt | selC1 | selDelay;
   wire signed [15:0] sData = $signed(wrData);
   wire inRange = (selMode & (wrData <= `DMS_MAX_MODE))
      | (selAbs & (wrData <= `DMS_MAX_ABS))
      | ((selDir | selPhase) & (wrData <= `DMS_MAX_BIT))
      | (selEnOff & (sData >= `DMS_MIN_ENOFF) & (sData <= `DMS_MAX_ENOFF))
      | (selC2 & (sData >= `DMS_MIN_C2) & (sData <= `DMS_MAX_C2))
      | (selOt & (wrData <= `DMS_MAX_OT))
      | (selC1 & (wrData <= `DMS_MAX_C1))
      | (selDelay & (wrData <= `DMS_MAX_DELAY));
   // at-stop fields; the three stop/delay fields below apply at once
   wire atStopSel = selMode | selAbs | selDir | selPhase | selOt | selC1;
   wire wrOk = wrReq & mapped & inRange & (!atStopSel | driveStopped); // see (R16)
   wire rdOk = rdReq & !wrReq & mapped;
   wire [15:0] rdMux = selMode ? modeReg : selAbs ? absReg : selDir ? dirReg
      : selPhase ? phaseReg : selEnOff ? enOffReg : selC2 ? c2Reg
      : selOt ? otReg : selC1 ? c1Reg : delayReg;

   // ************************************************
   // parameter store
   // ************************************************
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         modeReg <= `DMS_RST_MODE; // see (R1)
         absReg <= `DMS_RST_ABS; // see (R3)
         dirReg <= `DMS_RST_DIR; // see (R5)
         phaseReg <= `DMS_RST_PHASE; // see (R6)
         enOffReg <= `DMS_RST_ENOFF; // see (R7)
         c2Reg <= `DMS_RST_C2; // see (R10)
         otReg <= `DMS_RST_OT; // see (R13)
         c1Reg <= `DMS_RST_C1; // see (R14)
         delayReg <= `DMS_RST_DELAY; // see (R15)
      end else if (wrOk) begin
         if (selMode) modeReg <= wrData;
         if (selAbs) absReg <= wrData;
         if (selDir) dirReg <= wrData;
         if (selPhase) phaseReg <= wrData;
         if (selEnOff) enOffReg <= wrData;
         if (selC2) c2Reg <= wrData;
         if (selOt) otReg <= wrData;
         if (selC1) c1Reg <= wrData;
         if (selDelay) delayReg <= wrData;
      end
   end

   // host answer: one cycle after the request
   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ack <= 1'b0;
         reject <= 1'b0;
         rdData <= 16'h0000;
      end else begin
         ack <= wrOk | rdOk;
         reject <= (wrReq & !wrOk) | (rdReq & !wrReq & !mapped); // see (R16)
         rdData <= rdOk ? rdMux : 16'h0000;
      end
   end

   // ************************************************
   // mode and stop outputs
   // ************************************************
   wire [2:0] m = modeReg[2:0];
   // see (R1) (R2)
   wire speedNext = (m == 3'h0) | (m == 3'h3) | (m == 3'h4) | (m == 3'h6);
   wire posNext = (m == 3'h1) | (m == 3'h4) | (m == 3'h5) | (m == 3'h6);
   wire torqNext = (m == 3'h2) | (m == 3'h3) | (m == 3'h5) | (m == 3'h6);
   wire segNext = m == 3'h7;
   wire [4:0] enOffDec = decEnOff(enOffReg); // see (R7) (R8)
   wire [4:0] c2Dec = decC2(c2Reg); // see (R9) (R10)
   wire [4:0] otDec = decOt(otReg); // see (R11) (R12) (R13)
   wire [4:0] c1Dec = decC1(c1Reg); // see (R14)

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         speedModeEn <= 1'b0;
         positionModeEn <= 1'b1;
         torqueModeEn <= 1'b0;
         segmentModeEn <= 1'b0;
         absMode <= DMS_ABS_INC;
         clockwiseForward <= 1'b0;
         phaseALags <= 1'b0;
         {enOffAct, enOffEnd} <= {DMS_ACT_COAST, DMS_END_OFF};
         {c2Act, c2End} <= {DMS_ACT_RAMP2, DMS_END_OFF};
         {otAct, otEnd} <= {DMS_ACT_ZERO, DMS_END_LOCK};
         otIgnore <= 1'b0;
         {c1Act, c1End} <= {DMS_ACT_DBRAKE, DMS_END_DB};
      end else begin
         speedModeEn <= speedNext;
         positionModeEn <= posNext;
         torqueModeEn <= torqNext;
         segmentModeEn <= segNext;
         absMode <= dms_abs_t'(absReg[2:0]); // see (R3) (R4)
         clockwiseForward <= dirReg[0]; // see (R5)
         phaseALags <= phaseReg[0]; // see (R6)
         {enOffAct, enOffEnd} <= enOffDec;
         {c2Act, c2End} <= c2Dec;
         {otAct, otEnd} <= otDec;
         otIgnore <= otReg == `DMS_MAX_OT; // see (R13)
         {c1Act, c1End} <= c1Dec;
      end
   end

   // ************************************************
   // brake release command gate
   // ************************************************
   dms_brk_t brkState;
   logic [31:0] tickCount;
   logic [15:0] msCount;
   // the delay is sampled live, so a shorter write ends a running wait early
   wire msTick = tickCount == 32'(MS_CYCLES - 1);
   wire delayDone = msCount >= delayReg;

   always_ff @(posedge clock or negedge rstSyncN) begin
      if (!rstSyncN) begin
         brkState <= DMS_BRK_IDLE;
         tickCount <= 32'h0;
         msCount <= 16'h0000;
      end else begin
         case (brkState)
            DMS_BRK_IDLE: begin
               tickCount <= 32'h0;
               msCount <= 16'h0000;
               if (brakeReleaseOn) brkState <= DMS_BRK_WAIT;
            end
            DMS_BRK_WAIT: begin
               tickCount <= msTick ? 32'h0 : tickCount + 32'h1;
               if (msTick) msCount <= msCount + 16'h0001;
               if (!brakeReleaseOn) brkState <= DMS_BRK_IDLE;
               else if (delayDone) brkState <= DMS_BRK_READY; // see (R15)
            end
            DMS_BRK_READY: begin
               if (!brakeReleaseOn) brkState <= DMS_BRK_IDLE;
            end
            default: brkState <= DMS_BRK_IDLE;
         endcase
      end
   end
   assign cmdAccept = brkState == DMS_BRK_READY;

   // ************************************************
   // checks
   // ************************************************
   default clocking @(posedge clock); endclocking
   default disable iff (!rstSyncN);

   a_mode_stop_guard: assert property (wrReq && selMode && !driveStopped // see (R1)
      |=> reject && !ack && modeReg == $past(modeReg))
      else $error("mode changed while running");
   a_mode_compound: assert property (modeReg == 16'h0003 // see (R2)
      |=> torqueModeEn && speedModeEn && !positionModeEn && !segmentModeEn)
      else $error("torque/speed decode wrong");
   a_abs_single: assert property (absReg == 16'h0004 |=> absMode == DMS_ABS_SINGLE) // see (R4)
      else $error("single-turn decode wrong");
   a_dir_clockwise: assert property (dirReg == 16'h0001 |=> clockwiseForward) // see (R5)
      else $error("direction decode wrong");
   a_enoff_immediate: assert property (wrReq && selEnOff && wrData == 16'h0002 // see (R7)
      |=> ack && enOffReg == 16'h0002 ##1 enOffAct == DMS_ACT_DBRAKE && enOffEnd == DMS_END_OFF)
      else $error("enable-off write not immediate");
   a_enoff_negative: assert property (enOffReg == 16'hfffd // see (R8)
      |=> enOffAct == DMS_ACT_ZERO && enOffEnd == DMS_END_DB)
      else $error("enable-off zero speed decode wrong");
   a_class2_negative: assert property (c2Reg == 16'hfffb // see (R9)
      |=> c2Act == DMS_ACT_ZERO && c2End == DMS_END_DB)
      else $error("class 2 decode wrong");
   a_ot_ignore: assert property (otReg == 16'h0007 // see (R13)
      |=> otIgnore && otAct == DMS_ACT_NONE)
      else $error("overtravel ignore decode wrong");
   a_class1_hold: assert property (c1Reg == 16'h0002 // see (R14)
      |=> c1Act == DMS_ACT_DBRAKE && c1End == DMS_END_DB)
      else $error("class 1 decode wrong");
   a_range_keep: assert property (wrReq && selC2 && $signed(wrData) > `DMS_MAX_C2 // see (R16)
      |=> reject && $stable(c2Reg))
      else $error("out-of-range write stored");
   a_brake_hold: assert property (brkState == DMS_BRK_WAIT && !delayDone // see (R15)
      |-> !cmdAccept ##1 (brkState != DMS_BRK_READY))
      else $error("commands accepted before delay");
   a_abs_stop_guard: assert property (wrReq && selAbs && !driveStopped // see (R3)
      |=> reject && $stable(absReg))
      else $error("absolute system changed while running");
   a_phase_lag: assert property (phaseReg == 16'h0001 |=> phaseALags) // see (R6)
      else $error("phase order decode wrong");
   a_class2_brake: assert property (c2Reg == 16'h0004 // see (R10)
      |=> c2Act == DMS_ACT_DBRAKE && c2End == DMS_END_OFF)
      else $error("class 2 braking decode wrong");
   a_ot_lock: assert property (otReg == 16'h0001 // see (R11)
      |=> otAct == DMS_ACT_ZERO && otEnd == DMS_END_LOCK)
      else $error("overtravel lock decode wrong");
   a_ot_held: assert property (otReg == 16'h0006 // see (R12)
      |=> otAct == DMS_ACT_DBRAKE && otEnd == DMS_END_DB)
      else $error("overtravel held braking decode wrong");
endmodule : dms_config_bank
`default_nettype wire

// [rtl/dms_map.svh]
// register map, reset values, value limits and timing for the drive mode and stop bank
// What this block does
// (R1) Mode 0 is speed, 1 position and 2 torque, the field resets to position and changes only at stop.
// (R2) Mode 3 torque/speed, 4 speed/position, 5 torque/position, 6 all three, 7 process segment.
// (R3) Absolute 0 is incremental, 1 linear and 2 rotation, the field resets to 0 and changes at stop.
// (R4) Absolute 3 is linear without overflow warning and absolute 4 is single-turn.
// (R5) Direction 0 makes counterclockwise forward and 1 clockwise, resets to 0, changes at stop.
// (R6) Pulse phase 0 has A lead B and 1 has A lag B, resets to 0 and changes only at stop.
// (R7) Enable-off 0 coast, 1 ramp 1 and 2 braking all end off, reset 0, taking effect at once.
// (R8) Enable-off -1 braking, -2 ramp 1, -3 zero speed and -4 ramp 2 all end in dynamic braking.
// (R9) Class 2 -1 braking, -2 ramp 1, -3 ramp 2, -4 stop torque and -5 zero speed all end braked.
// (R10) Class 2 0 coast, 1 ramp 1, 2 ramp 2, 3 stop torque and 4 braking all end off, reset 2.
// (R11) Overtravel 0 coast off, 1 zero speed locked, 2 zero speed off and 3 ramp 2 off.
// (R12) Overtravel 4 ramp 2 locked, 5 dynamic braking off and 6 dynamic braking held.
// (R13) Overtravel 7 ignores overtravel, the field resets to 1 and changes only at stop.
// (R14) Class 1 0 coast off, 1 braking off and 2 braking held, reset 2, changes only at stop.
// (R15) Commands wait 0 to 500 ms (reset 250) after brake release, and new delays apply at once.
// (R16) An out-of-set write, or an at-stop write while running, is rejected and changes nothing.
// (R17) The host writes at-stop fields only when stopped and only values inside each set; the bench also sends such writes to check they are rejected.
`ifndef DMS_MAP_SVH
`define DMS_MAP_SVH
`define DMS_ADDR_MODE 16'h0200
`define DMS_ADDR_ABS 16'h0201
`define DMS_ADDR_DIR 16'h0202
`define DMS_ADDR_PHASE 16'h0203
`define DMS_ADDR_ENOFF 16'h0205
`define DMS_ADDR_C2 16'h0206
`define DMS_ADDR_OT 16'h0207
`define DMS_ADDR_C1 16'h0208
`define DMS_ADDR_DELAY 16'h0209
`define DMS_RST_MODE 16'h0001
`define DMS_RST_ABS 16'h0000
`define DMS_RST_DIR 16'h0000
`define DMS_RST_PHASE 16'h0000
`define DMS_RST_ENOFF 16'h0000
`define DMS_RST_C2 16'h0002
`define DMS_RST_OT 16'h0001
`define DMS_RST_C1 16'h0002
`define DMS_RST_DELAY 16'h00fa
`define DMS_MAX_MODE 16'h0007
`define DMS_MAX_ABS 16'h0004
`define DMS_MAX_BIT 16'h0001
`define DMS_MIN_ENOFF (-16'sh0004)
`define DMS_MAX_ENOFF 16'sh0002
`define DMS_MIN_C2 (-16'sh0005)
`define DMS_MAX_C2 16'sh0004
`define DMS_MAX_OT 16'h0007
`define DMS_MAX_C1 16'h0002
`define DMS_MAX_DELAY 16'h01f4
`define DMS_MS_NS 1000000
`define DMS_CLK_NS 8
`endif

// [rtl/dms_pkg.sv]
// types shared by the drive mode and stop bank
package dms_pkg;
   typedef enum logic [2:0] {
      DMS_ACT_COAST = 3'h0,
      DMS_ACT_RAMP1 = 3'h1,
      DMS_ACT_RAMP2 = 3'h2,
      DMS_ACT_ZERO = 3'h3,
      DMS_ACT_ETORQ = 3'h4,
      DMS_ACT_DBRAKE = 3'h5,
      DMS_ACT_NONE = 3'h6
   } dms_act_t;
   typedef enum logic [1:0] {
      DMS_END_OFF = 2'h0,
      DMS_END_DB = 2'h1,
      DMS_END_LOCK = 2'h2,
      DMS_END_RUN = 2'h3
   } dms_end_t;
   typedef enum logic [2:0] {
      DMS_ABS_INC = 3'h0,
      DMS_ABS_LIN = 3'h1,
      DMS_ABS_ROT = 3'h2,
      DMS_ABS_LIN_NOWARN = 3'h3,
      DMS_ABS_SINGLE = 3'h4
   } dms_abs_t;
   typedef enum logic [2:0] {
      DMS_BRK_IDLE = 3'b001,
      DMS_BRK_WAIT = 3'b010,
      DMS_BRK_READY = 3'b100
   } dms_brk_t;
endpackage : dms_pkg

// [verification/dms_host_model.sv]
// host controller model issuing parameter reads and writes one word at a time
`timescale 1ns/1ns
`default_nettype none
module dms_host_model (
   input wire logic clock,
   input wire logic ack,
   input wire logic reject,
   input wire logic [15:0] rdData,
   output logic wrReq,
   output logic rdReq,
   output logic [15:0] addr,
   output logic [15:0] wrData
);
   // ********
   // bus cycle
   // ********
   initial begin
      wrReq = 1'b0;
      rdReq = 1'b0;
      addr = 16'h0000;
      wrData = 16'h0000;
   end
   // one request per call; the bench also sends out-of-range and while-running at-stop writes to check they are rejected
   task automatic xfer(input logic isWr, input logic [15:0] a, input logic [15:0] d,
         output logic gotAck, output logic gotRej, output logic [15:0] data);
      int n;
      @(posedge clock);
      wrReq <= isWr;
      rdReq <= ~isWr;
      addr <= a;
      wrData <= d;
      @(posedge clock);
      wrReq <= 1'b0;
      rdReq <= 1'b0;
      // released lines carry the inverse so a stale value cannot pass for a live one
      addr <= ~a;
      wrData <= ~d;
      gotAck = 1'b0;
      gotRej = 1'b0;
      data = 16'h0000;
      // the answer is a one-cycle pulse from the edge that took the request, so read it now
      for (n = 0; n < 4 && !(gotAck || gotRej); n++) begin
         #1;
         gotAck = ack;
         gotRej = reject;
         data = rdData;
         if (!(gotAck || gotRej)) @(posedge clock);
      end
   endtask : xfer
endmodule : dms_host_model
`default_nettype wire

// [verification/tb_top.sv]
// self-checking bench for the drive mode and stop bank
`timescale 1ns/1ns
`include "dms_map.svh"
`default_nettype none
module tb_top;
   import dms_pkg::*;
   localparam int MS = 4;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic driveStopped = 1'b1;
   logic brakeReleaseOn = 1'b0;
   logic wrReq, rdReq, ack, reject, cmdAccept, otIgnore, clockwiseForward, phaseALags;
   logic speedModeEn, positionModeEn, torqueModeEn, segmentModeEn;
   logic [15:0] addr, wrData, rdData;
   dms_abs_t absMode;
   dms_act_t enOffAct, c2Act, otAct, c1Act;
   dms_end_t enOffEnd, c2End, otEnd, c1End;
   int n_errors = 0;
   int n_tests = 0;
   logic [15:0] regAddr [9] = '{`DMS_ADDR_MODE, `DMS_ADDR_ABS, `DMS_ADDR_DIR, `DMS_ADDR_PHASE,
      `DMS_ADDR_ENOFF, `DMS_ADDR_C2, `DMS_ADDR_OT, `DMS_ADDR_C1, `DMS_ADDR_DELAY};
   logic [15:0] regRst [9] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002,
      16'h0001, 16'h0002, 16'h00fa};
   always #4 clock = ~clock;
   dms_config_bank #(.MS_CYCLES(MS)) dut (.clock(clock), .rst_n(rst_n), .wrReq(wrReq),
      .rdReq(rdReq), .addr(addr), .wrData(wrData), .rdData(rdData), .ack(ack), .reject(reject),
      .driveStopped(driveStopped), .brakeReleaseOn(brakeReleaseOn), .cmdAccept(cmdAccept),
      .speedModeEn(speedModeEn), .positionModeEn(positionModeEn), .torqueModeEn(torqueModeEn),
      .segmentModeEn(segmentModeEn), .absMode(absMode), .clockwiseForward(clockwiseForward),
      .phaseALags(phaseALags), .enOffAct(enOffAct), .enOffEnd(enOffEnd), .c2Act(c2Act),
      .c2End(c2End), .otAct(otAct), .otEnd(otEnd), .otIgnore(otIgnore), .c1Act(c1Act),
      .c1End(c1End));
   dms_host_model host (.clock(clock), .ack(ack), .reject(reject), .rdData(rdData),
      .wrReq(wrReq), .rdReq(rdReq), .addr(addr), .wrData(wrData));
   // ********
   // helpers
   // ********
   task automatic complete_run();
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, seen);
         n_errors++;
      end
   endtask : check
   task automatic xfer(input logic isWr, input logic [15:0] a, input logic [15:0] d,
         input logic expAck, input logic [15:0] expData);
      logic ga, gr;
      logic [15:0] gd;
      host.xfer(isWr, a, d, ga, gr, gd);
      if (ga !== 1'b1 && gr !== 1'b1) begin
         n_errors++;
         complete_run();
      end
      check("ack", {15'h0, ga}, {15'h0, expAck});
      check("reject", {15'h0, gr}, {15'h0, !expAck});
      if (!isWr && expAck) begin
         check("read data", gd, expData);
      end
      // decoded outputs trail the register by one cycle
      @(posedge clock);
      #1;
   endtask : xfer
   // packs action and ending as {act, end}
   function automatic logic [4:0] stopOut(input int which);
      case (which)
         0: return {enOffAct, enOffEnd};
         1: return {c2Act, c2End};
         2: return {otAct, otEnd};
         default: return {c1Act, c1End};
      endcase
   endfunction : stopOut
   task automatic sweep(input int which, input int lo, input int n, input logic [4:0] t [10]);
      for (int i = 0; i < n; i++) begin
         xfer(1'b1, regAddr[which == 3 ? 7 : which + 4], 16'(lo + i), 1'b1, 16'h0);
         check("stop action", {11'h0, stopOut(which)},
            {11'h0, t[i]});
      end
   endtask : sweep
   // ********
   // scenarios
   // ********
   task automatic test_reset();
      for (int i = 0; i < 9; i++) begin
         xfer(1'b0, regAddr[i], 16'h0, 1'b1,
            regRst[i]);
      end
      check("mode", {12'h0, segmentModeEn, torqueModeEn, positionModeEn, speedModeEn},
         16'h2);
      check("abs", {13'h0, absMode}, 16'h0);
      check("dir phase", {14'h0, clockwiseForward, phaseALags}, 16'h0);
      check("stops", {1'b0, stopOut(0), stopOut(1), stopOut(2)},
         16'h010e);
      check("c1 stop", {11'h0, stopOut(3)}, 16'h15);
      check("accept idle", {15'h0, cmdAccept}, 16'h0);
      $display("test reset done");
   endtask : test_reset
   task automatic test_reject();
      logic [15:0] bad [9] = '{16'h0008, 16'h0005, 16'h0002, 16'h0002, 16'h0003, 16'hfffa,
         16'h0008, 16'h0003, 16'h01f5};
      logic [15:0] ok [9] = '{16'h0000, 16'h0001, 16'h0001, 16'h0001, 16'hffff, 16'hfffb,
         16'h0000, 16'h0001, 16'h01f4};
      for (int i = 0; i < 9; i++) begin
         xfer(1'b1, regAddr[i], bad[i], 1'b0, 16'h0);
         xfer(1'b0, regAddr[i], 16'h0, 1'b1, regRst[i]);
      end
      xfer(1'b1, `DMS_ADDR_ENOFF, 16'hfffb, 1'b0, 16'h0);
      xfer(1'b1, `DMS_ADDR_C2, 16'h0005, 1'b0, 16'h0);
      xfer(1'b0, `DMS_ADDR_C2, 16'h0, 1'b1, `DMS_RST_C2);
      xfer(1'b1, 16'h0204, 16'h0000, 1'b0, 16'h0);
      xfer(1'b0, 16'h0204, 16'h0000, 1'b0, 16'h0);
      @(posedge clock);
      driveStopped <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         xfer(1'b1, regAddr[i], ok[i], i inside {4, 5, 8},
            16'h0);
         xfer(1'b0, regAddr[i], 16'h0, 1'b1,
            i inside {4, 5, 8} ? ok[i] : regRst[i]);
      end
      @(posedge clock);
      driveStopped <= 1'b1;
      $display("test reject done");
   endtask : test_reject
   task automatic test_decode();
      logic [3:0] en [8] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h3, 4'h6, 4'h7, 4'h8};
      for (int i = 0; i < 8; i++) begin
         xfer(1'b1, `DMS_ADDR_MODE, 16'(i), 1'b1, 16'h0);
         check("mode", {12'h0, segmentModeEn, torqueModeEn, positionModeEn, speedModeEn},
            {12'h0, en[i]});
      end
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, `DMS_ADDR_ABS, 16'(i), 1'b1, 16'h0);
         check("abs", {13'h0, absMode}, 16'(i));
      end
      for (int i = 1; i >= 0; i--) begin
         xfer(1'b1, `DMS_ADDR_DIR, 16'(i), 1'b1, 16'h0);
         xfer(1'b1, `DMS_ADDR_PHASE, 16'(1 - i), 1'b1, 16'h0);
         check("dir phase", {14'h0, clockwiseForward, phaseALags},
            16'(2 * i + 1 - i));
      end
      sweep(0, -4, 7, '{5'h09, 5'h0d, 5'h05, 5'h15, 5'h00, 5'h04, 5'h14, 5'h0, 5'h0,
         5'h0});
      sweep(1, -5, 10, '{5'h0d, 5'h11, 5'h09, 5'h05, 5'h15, 5'h00, 5'h04, 5'h08, 5'h10,
         5'h14});
      sweep(2, 0, 7, '{5'h00, 5'h0e, 5'h0c, 5'h08, 5'h0a, 5'h14, 5'h15, 5'h0, 5'h0,
         5'h0});
      sweep(3, 0, 3, '{5'h00, 5'h14, 5'h15, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0, 5'h0,
         5'h0});
      check("ot ignore", {15'h0, otIgnore}, 16'h0);
      xfer(1'b1, `DMS_ADDR_OT, 16'h0007, 1'b1, 16'h0);
      check("ot ignore", {15'h0, otIgnore}, 16'h1);
      $display("test decode done");
   endtask : test_decode
   task automatic test_brake(input int d);
      int n;
      xfer(1'b1, `DMS_ADDR_DELAY, 16'(d), 1'b1, 16'h0);
      @(posedge clock);
      brakeReleaseOn <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (cmdAccept !== 1'b1 && n < 3000);
      check("accept not early", 16'(n >= d * MS), 16'h1);
      check("accept not late", 16'(n <= d * MS + 3), 16'h1);
      if (n >= 3000) complete_run();
      @(posedge clock);
      brakeReleaseOn <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      check("accept drop", {15'h0, cmdAccept}, 16'h0);
      $display("test brake %0d done", d);
   endtask : test_brake
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      repeat (3) @(posedge clock);
      test_reset();
      test_reject();
      test_decode();
      test_brake(0);
      test_brake(3);
      test_brake(500);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
